/* File: hw/palette_host_port.sv */
`timescale 1ns/1ps
// Behaviour
// - Select latched at strobe falling edge
// - Eight-bit two-way data bus transfers
// - Write data taken at strobe rise
// - Drive during read, release on rise
// - Host keeps gaps; async timing absorbed
// - Decode select: address, colour, mask
// - Colour as red, green, blue bytes
// - Third write stores entry, bumps address
// - Read-address write loads colour, bumps
module palette_host_port
  import php_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              readStrobeN,
  input  wire logic              writeStrobeN,
  input  wire logic              reg_select_lo,
  input  wire logic              reg_select_hi,
  input  wire logic [DATA_W-1:0] host_data_bus_in,
  output logic      [DATA_W-1:0] host_data_bus_out,
  output logic                   host_data_bus_oe,
  input  wire logic [7:0]        pixelAddr,
  output logic      [17:0]       pixelColour,
  output logic      [7:0]        pixelMask
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  php_pins_t pinsAsync;
  php_pins_t pins;
  logic [DATA_W-1:0] dataS1_r, dataS2_r;

  assign pinsAsync = '{readN: readStrobeN, writeN: writeStrobeN,
                       sel: {reg_select_hi, reg_select_lo}};

  php_sync i_php_sync (
    .core_clk  (core_clk),
    .rst       (rst),
    .pinsAsync (pinsAsync),
    .pinsSync  (pins)
  );

  // Data is stable around the write rise; two flops keep it aligned with strobes
  always_ff @(posedge core_clk) begin
    dataS1_r <= host_data_bus_in;
    dataS2_r <= dataS1_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised strobes
  logic readPrev_r, writePrev_r;
  logic readFall, readRise, writeFall, writeRise;
  logic [1:0] selHeld_r, selHeld_nxt;
  logic readActive_r, readActive_nxt;

  always_ff @(posedge core_clk) begin
    readPrev_r  <= rst ? 1'b1 : pins.readN;
    writePrev_r <= rst ? 1'b1 : pins.writeN;
  end

  // Both strobes low is host misuse; write takes precedence then
  assign readFall  = readPrev_r & ~pins.readN & pins.writeN;
  assign readRise  = ~readPrev_r & pins.readN;
  assign writeFall = writePrev_r & ~pins.writeN;
  assign writeRise = ~writePrev_r & pins.writeN;

  // Latch select at the falling strobe edge
  always_comb begin
    selHeld_nxt    = selHeld_r;
    readActive_nxt = readActive_r;
    if (writeFall || readFall) begin
      selHeld_nxt = pins.sel;
    end
    if (readFall) begin
      readActive_nxt = 1'b1;
    end else if (readRise) begin
      readActive_nxt = 1'b0;
    end
    if (rst) begin
      selHeld_nxt    = SEL_ADDR_WR;
      readActive_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    selHeld_r    <= selHeld_nxt;
    readActive_r <= readActive_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and look-up table
  logic [17:0] table_r [ENTRIES];
  logic [7:0]  addr_r, addr_nxt;
  logic [7:0]  mask_r, mask_nxt;
  logic [17:0] colour_r, colour_nxt;
  logic [1:0]  phase_r, phase_nxt;
  logic        tableWr;
  logic [DATA_W-1:0] readData;

  // Register update on completed cycles
  always_comb begin
    addr_nxt   = addr_r;
    mask_nxt   = mask_r;
    colour_nxt = colour_r;
    phase_nxt  = phase_r;
    tableWr    = 1'b0;
    if (writeRise) begin
      unique case (selHeld_r)
        SEL_ADDR_WR: begin
          addr_nxt  = dataS2_r;
          phase_nxt = PHASE_RST;
        end
        SEL_ADDR_RD: begin
          colour_nxt = table_r[dataS2_r];
          addr_nxt   = dataS2_r + 8'h01;
          phase_nxt  = PHASE_RST;
        end
        SEL_MASK: begin
          mask_nxt = dataS2_r;
        end
        SEL_COLOUR: begin
          // Only low six bits kept, red first
          unique case (phase_r)
            2'h0:    colour_nxt[RED_LSB+:COMP_W]   = dataS2_r[COMP_W-1:0];
            2'h1:    colour_nxt[GREEN_LSB+:COMP_W] = dataS2_r[COMP_W-1:0];
            default: colour_nxt[BLUE_LSB+:COMP_W]  = dataS2_r[COMP_W-1:0];
          endcase
          if (phase_r == PHASE_LAST) begin
            tableWr   = 1'b1;
            addr_nxt  = addr_r + 8'h01;
            phase_nxt = PHASE_RST;
          end else begin
            phase_nxt = phase_r + 2'h1;
          end
        end
      endcase
    end else if (readRise && selHeld_r == SEL_COLOUR) begin
      // Third byte read refills colour from the next entry
      if (phase_r == PHASE_LAST) begin
        colour_nxt = table_r[addr_r];
        addr_nxt   = addr_r + 8'h01;
        phase_nxt  = PHASE_RST;
      end else begin
        phase_nxt = phase_r + 2'h1;
      end
    end
    if (rst) begin
      addr_nxt   = ADDR_RST;
      mask_nxt   = MASK_RST;
      colour_nxt = COLOUR_RST;
      phase_nxt  = PHASE_RST;
      tableWr    = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    addr_r   <= addr_nxt;
    mask_r   <= mask_nxt;
    colour_r <= colour_nxt;
    phase_r  <= phase_nxt;
  end

  // Table storage; contents are undefined until written, as on a real palette
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
      always_ff @(posedge core_clk) begin
        if (tableWr && addr_r == 8'(gi)) begin
          table_r[gi] <= colour_nxt;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data and bus drive
  // Select taken from its next value: the old code would show a stale byte
  // in the first driven cycle of a read
  always_comb begin
    readData = 8'h00;
    unique case (selHeld_nxt)
      SEL_ADDR_WR, SEL_ADDR_RD: readData = addr_r;
      SEL_MASK:                 readData = mask_r;
      SEL_COLOUR: begin
        // Upper two bits read as zero
        unique case (phase_r)
          2'h0:    readData = {2'h0, colour_r[RED_LSB+:COMP_W]};
          2'h1:    readData = {2'h0, colour_r[GREEN_LSB+:COMP_W]};
          default: readData = {2'h0, colour_r[BLUE_LSB+:COMP_W]};
        endcase
      end
    endcase
  end

  logic [DATA_W-1:0] busOut_r;
  logic              busOe_r;
  logic [17:0]       pixOut_r;

  always_ff @(posedge core_clk) begin
    busOut_r <= rst ? 8'h00 : readData;
    busOe_r  <= rst ? 1'b0 : readActive_nxt;
    pixOut_r <= rst ? COLOUR_RST : table_r[pixelAddr & mask_r];
  end

  assign host_data_bus_out = busOut_r;
  assign host_data_bus_oe  = busOe_r;
  assign pixelColour       = pixOut_r;
  assign pixelMask         = mask_r;
endmodule // palette_host_port

/* File: hw/php_pkg.sv */
package php_pkg;
  // Register select codes
  localparam logic [1:0] SEL_ADDR_WR = 2'h0;
  localparam logic [1:0] SEL_COLOUR  = 2'h1;
  localparam logic [1:0] SEL_MASK    = 2'h2;
  localparam logic [1:0] SEL_ADDR_RD = 2'h3;
  // Widths and table size
  localparam int DATA_W    = 8;
  localparam int COMP_W    = 6;
  localparam int ENTRIES   = 256;
  localparam int BYTES_PER = 3;
  // Reset values and the last colour phase
  localparam logic [7:0]  ADDR_RST   = 8'h00;
  localparam logic [7:0]  MASK_RST   = 8'hff;
  localparam logic [17:0] COLOUR_RST = 18'h00000;
  localparam logic [1:0]  PHASE_RST  = 2'h0;
  localparam logic [1:0]  PHASE_LAST = 2'h2;
  // Field positions inside the colour word
  localparam int RED_LSB   = 12;
  localparam int GREEN_LSB = 6;
  localparam int BLUE_LSB  = 0;

  // Strobe and select pins as seen after synchronising
  typedef struct packed {
    logic       readN;
    logic       writeN;
    logic [1:0] sel;
  } php_pins_t;

  // One completed host cycle
  typedef struct packed {
    logic       isWrite;
    logic [1:0] sel;
  } php_event_t;
endpackage

/* File: hw/php_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for a group of pin levels
module php_sync
  import php_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst,
  input  wire php_pins_t pinsAsync,
  output php_pins_t      pinsSync
);
  php_pins_t stage1_r, stage1_nxt;
  php_pins_t stage2_r, stage2_nxt;

  // Next values; idle strobes high after reset
  always_comb begin
    stage1_nxt = pinsAsync;
    stage2_nxt = stage1_r;
    if (rst) begin
      stage1_nxt = '{readN: 1'b1, writeN: 1'b1, sel: 2'h0};
      stage2_nxt = '{readN: 1'b1, writeN: 1'b1, sel: 2'h0};
    end
  end

  // Registers only
  always_ff @(posedge core_clk) begin
    stage1_r <= stage1_nxt;
    stage2_r <= stage2_nxt;
  end

  assign pinsSync = stage2_r;
endmodule // php_sync

/* File: sim/palette_host_port_tb_top.sv */
`timescale 1ns/1ps
// Host-port bench: register traffic through the host model
module palette_host_port_tb_top
  import php_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        rdN, wrN, devOe;
  logic [1:0]  sel;
  logic [7:0]  busLine, devData, pixelMask;
  logic [7:0]  pixelAddr = 8'h00;
  logic [17:0] pixelColour;
  int          n_mismatch = 0, n_checks = 0, cycles = 0;
  initial forever #5 core_clk = ~core_clk;
  palette_host_port i_palette_host_port (.core_clk(core_clk), .rst(rst), .readStrobeN(rdN),
    .writeStrobeN(wrN), .reg_select_lo(sel[0]), .reg_select_hi(sel[1]),
    .host_data_bus_in(busLine), .host_data_bus_out(devData), .host_data_bus_oe(devOe),
    .pixelAddr(pixelAddr), .pixelColour(pixelColour), .pixelMask(pixelMask));
  php_host_model i_php_host_model (.core_clk(core_clk), .devData(devData), .devOe(devOe),
    .readStrobeN(rdN), .writeStrobeN(wrN), .sel(sel), .busLine(busLine));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Mask written, read back, seen at its output
  task automatic t_mask();
    logic [7:0] d;
    i_php_host_model.wr(SEL_MASK, 8'h1f);
    i_php_host_model.rd(SEL_MASK, d);
    chk("mask read", 18'h0001f, 18'(d));
    chk("mask out", 18'h0001f, 18'(pixelMask));
  endtask
  // Two entries written with junk top bits, read back in order
  task automatic t_colour();
    logic [7:0] d;
    logic [7:0] b [6] = '{8'hea, 8'h15, 8'hff, 8'hc1, 8'h02, 8'h43};
    i_php_host_model.wr(SEL_ADDR_WR, 8'h10);
    foreach (b[i]) i_php_host_model.wr(SEL_COLOUR, b[i]);
    i_php_host_model.wr(SEL_ADDR_RD, 8'h10);
    foreach (b[i]) begin
      i_php_host_model.rd(SEL_COLOUR, d);
      chk("colour byte", 18'(b[i] & 8'h3f), 18'(d));
    end
    i_php_host_model.rd(SEL_ADDR_WR, d);
    chk("address", 18'h00013, 18'(d));
    i_php_host_model.rd(SEL_ADDR_RD, d);
    chk("address alias", 18'h00013, 18'(d));
  endtask
  // Masked pixel index picks the stored entries; mask read after another select
  task automatic t_pixel();
    logic [7:0] d;
    i_php_host_model.rd(SEL_MASK, d);
    chk("mask after colour", 18'h0001f, 18'(d));
    pixelAddr = 8'h30;
    repeat (3) @(negedge core_clk);
    chk("pixel colour", 18'h2a57f, pixelColour);
    pixelAddr = 8'h31;
    repeat (3) @(negedge core_clk);
    chk("pixel colour", 18'h01083, pixelColour);
  endtask
  // Hang guard: the sequence needs about 330 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("mask reset", 18'h000ff, 18'(pixelMask));
    t_mask();
    t_colour();
    t_pixel();
    stop_test();
  end
endmodule // palette_host_port_tb_top

/* File: sim/php_checker.sv */
`timescale 1ns/1ps
// Port checks; windows allow for the two-flop strobe synchroniser
module php_checker
  import php_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              readStrobeN,
  input wire logic              writeStrobeN,
  input wire logic              reg_select_lo,
  input wire logic              reg_select_hi,
  input wire logic [DATA_W-1:0] host_data_bus_in,
  input wire logic [DATA_W-1:0] host_data_bus_out,
  input wire logic              host_data_bus_oe,
  input wire logic [7:0]        pixelMask
);
  logic [1:0] code;
  assign code = {reg_select_hi, reg_select_lo};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  bus_idle_a: assert property (readStrobeN [*6] |-> !host_data_bus_oe)
    else $error("bus driven without a read");
  drive_start_a: assert property ($fell(readStrobeN) && writeStrobeN |-> ##[3:5] host_data_bus_oe)
    else $error("read not answered");
  drive_cause_a: assert property ($rose(host_data_bus_oe) |-> !readStrobeN && !$past(readStrobeN, 2))
    else $error("drive began without read strobe");
  bus_release_a: assert property ($rose(readStrobeN) |-> ##[3:5] !host_data_bus_oe)
    else $error("bus not released");
  drive_hold_a: assert property (host_data_bus_oe && !readStrobeN |=> host_data_bus_oe)
    else $error("drive dropped mid read");
  mask_load_a: assert property ($rose(writeStrobeN) && code == SEL_MASK |-> ##[2:5] pixelMask == host_data_bus_in)
    else $error("mask write lost");
  mask_read_a: assert property (host_data_bus_oe && code == SEL_MASK |-> host_data_bus_out == pixelMask)
    else $error("mask read wrong");
  colour_pad_a: assert property (host_data_bus_oe && code == SEL_COLOUR |-> host_data_bus_out[7:6] == 2'h0)
    else $error("colour byte top bits set");
  cover property ($rose(writeStrobeN) && code == SEL_MASK);
  cover property (host_data_bus_oe && code == SEL_COLOUR);
  cover property (host_data_bus_oe && code == SEL_ADDR_WR);
endmodule // php_checker
bind palette_host_port php_checker i_php_checker (.core_clk(core_clk), .rst(rst),
  .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .reg_select_lo(reg_select_lo),
  .reg_select_hi(reg_select_hi), .host_data_bus_in(host_data_bus_in),
  .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
  .pixelMask(pixelMask));

/* File: sim/php_host_model.sv */
`timescale 1ns/1ps
// Host processor side: strobes, select and the shared data wire
module php_host_model
  import php_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic [DATA_W-1:0] devData,
  input  wire logic              devOe,
  output logic                   readStrobeN,
  output logic                   writeStrobeN,
  output logic [1:0]             sel,
  output logic [DATA_W-1:0]      busLine
);
  logic              hostOe = 1'b0;
  logic [DATA_W-1:0] hostData = '0;
  logic [DATA_W-1:0] lastLine = '0;
  initial begin
    readStrobeN = 1'b1;
    writeStrobeN = 1'b1;
    sel = SEL_ADDR_WR;
  end
  // Undriven wire toggles so stale read data never passes
  always_ff @(posedge core_clk) lastLine <= busLine;
  assign busLine = hostOe ? hostData : (devOe ? devData : ~lastLine);
  ////////////////////////////////////////////////////////////////
  // Write: data and select held well past the rising strobe
  task automatic wr(input logic [1:0] code, input logic [7:0] d);
    @(negedge core_clk);
    sel = code;
    hostData = d;
    hostOe = 1'b1;
    writeStrobeN = 1'b0;
    repeat (10) @(negedge core_clk);
    writeStrobeN = 1'b1;
    repeat (5) @(negedge core_clk);
    hostOe = 1'b0;
  endtask
  // Read: sample the wire just before releasing the strobe
  task automatic rd(input logic [1:0] code, output logic [7:0] d);
    @(negedge core_clk);
    sel = code;
    readStrobeN = 1'b0;
    repeat (10) @(negedge core_clk);
    d = busLine;
    readStrobeN = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask
endmodule // php_host_model
